// [logic/fpsl_host.sv]
// host-side controller for the flash program, status and lockdown sequences
// software drives it over apb; the flash is reached through its parallel pins
//
// Design decisions made here: the APB slave port and the register offsets.
`timescale 1ns/1ps
module fpsl_host
  import fpsl_pkg::*;
#(
  parameter int          T_WE_LOW_NS     = 100,
  parameter int          T_ACC_NS        = 100,
  parameter logic [19:0] UNLOCK1_ADDR    = 20'h0_0555,
  parameter logic [19:0] UNLOCK2_ADDR    = 20'h0_02AA,
  parameter logic [15:0] UNLOCK1_DATA    = 16'h00AA,
  parameter logic [15:0] UNLOCK2_DATA    = 16'h0055,
  parameter logic [15:0] CMD_PROGRAM     = 16'h00A0,
  parameter logic [15:0] CMD_SET_CFG     = 16'h00D0,
  parameter logic [15:0] CMD_LOCK_SETUP  = 16'h0080,
  parameter logic [15:0] CMD_LOCK        = 16'h0060,
  parameter logic [15:0] CMD_ID_ENTRY    = 16'h0090,
  parameter logic [15:0] CMD_ID_EXIT     = 16'h00F0
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  output logic      [19:0] flash_addr_o,
  output logic      [15:0] flash_dq_o,
  output logic             flash_dq_oe_o,
  input  wire logic [15:0] flash_dq_i,
  output logic             flash_ce_n_o,
  output logic             flash_oe_n_o,
  output logic             flash_we_n_o,
  output logic             flash_rst_n_o
);
  localparam int WE_CYC   = (T_WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACC_CYC  = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_CYC = ACC_CYC + SYNC_LATENCY;
  if (T_WE_LOW_NS < 1 || T_ACC_NS < 1) begin : g_bad_time
    $error("fpsl_host: timing figures must be positive");
  end
  typedef enum logic [5:0] {
    S_IDLE = 6'b000001, S_STEP = 6'b000010, S_WAIT  = 6'b000100,
    S_POLL = 6'b001000, S_PWAIT = 6'b010000, S_RESET = 6'b100000
  } fpsl_state_e;
  fpsl_state_e state;
  fpsl_op_e    op_q;
  fpsl_step_e  kind;
  logic [2:0]  idx;
  logic [19:0] addr_q, bus_addr;
  logic [15:0] wdata_q, rdata_q, bus_data, bus_rdata, dq_sync;
  logic [7:0]  rst_cnt;
  logic        cfg_hold;
  logic        done_f, fail_f, low_f, lock_f, refused_f, badcfg_f;
  logic        have_prev, prev_toggle, recheck, busy, stopped, flagged;
  logic        bus_start, bus_write, bus_done;
  logic        wr_acc, start_req;
  fpsl_op_e    req_op;
  // apb offset to register index, shared by read and write
  function automatic logic [2:0] reg_index(input logic [7:0] a);
    case (a)
      OFS_CTRL:   return 3'h1;
      OFS_ADDR:   return 3'h2;
      OFS_WDATA:  return 3'h3;
      OFS_STATUS: return 3'h4;
      OFS_RDATA:  return 3'h5;
      default:    return 3'h0;
    endcase
  endfunction
  // command byte of each operation
  function automatic logic [15:0] cmd_code(input fpsl_op_e op, input logic [2:0] i);
    case (op)
      OP_PROGRAM:    return CMD_PROGRAM;
      OP_SET_CFG:    return CMD_SET_CFG;
      OP_LOCKDOWN:   return (i == 3'h2) ? CMD_LOCK_SETUP : CMD_LOCK;
      OP_LOCK_QUERY: return CMD_ID_ENTRY;
      default:       return CMD_ID_EXIT;
    endcase
  endfunction
  assign busy      = (state != S_IDLE);
  assign stopped   = have_prev && bus_rdata[DQ_TOGGLE] == prev_toggle;
  assign flagged   = have_prev && (bus_rdata[DQ_FAIL] || bus_rdata[DQ_LOW_SUPPLY]);
  assign kind      = fpsl_step(op_q, idx);
  assign wr_acc    = psel_i && penable_i && pwrite_i;
  assign req_op    = fpsl_op_e'(pwdata_i[2:0]);
  // only a reset may interrupt; other commands written while busy are refused and dropped
  assign start_req = wr_acc && (reg_index(paddr_i) == 3'h1) && req_op != OP_NONE
                     && (!busy || req_op == OP_HW_RESET);
  // apb slave: zero wait states, unmapped offsets answer with an error
  assign pready_o = psel_i && penable_i;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else if (psel_i && !penable_i) begin
      pslverr_o <= (reg_index(paddr_i) == 3'h0);
      case (reg_index(paddr_i))
        3'h1: prdata_o <= {29'h0000_0000, op_q};
        3'h2: prdata_o <= {12'h000, addr_q};
        3'h3: prdata_o <= {16'h0000, wdata_q};
        3'h4: prdata_o <= {24'h00_0000, badcfg_f, cfg_hold, refused_f, lock_f,
                           low_f, fail_f, done_f, busy};
        3'h5: prdata_o <= {16'h0000, rdata_q};
        default: prdata_o <= 32'h0000_0000;
      endcase
    end
  end
  // loaded address and data, frozen while busy
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      addr_q  <= 20'h0_0000;
      wdata_q <= 16'h0000;
    end else if (wr_acc && !busy) begin
      if (reg_index(paddr_i) == 3'h2) begin
        addr_q <= pwdata_i[19:0];
      end
      if (reg_index(paddr_i) == 3'h3) begin
        wdata_q <= pwdata_i[15:0];
      end
    end
  end
  // drive the bus engine from the current step
  always_comb begin
    bus_start = 1'b0;
    bus_write = 1'b1;
    bus_addr  = addr_q;
    bus_data  = wdata_q;
    if (state == S_STEP && kind != K_END) begin
      bus_start = 1'b1;
      case (kind)
        K_UNLOCK1: begin
          bus_addr = UNLOCK1_ADDR;
          bus_data = UNLOCK1_DATA;
        end
        K_UNLOCK2: begin
          bus_addr = UNLOCK2_ADDR;
          bus_data = UNLOCK2_DATA;
        end
        K_CMD: begin
          bus_addr = UNLOCK1_ADDR;
          bus_data = cmd_code(op_q, idx);
        end
        K_USER_CMD: bus_data = cmd_code(op_q, idx);
        K_READ: begin
          bus_write = 1'b0;
          bus_addr  = (op_q == OP_LOCK_QUERY) ? (addr_q | LOCK_IND_OFS) : addr_q;
        end
        default: bus_data = wdata_q;
      endcase
    end else if (state == S_POLL) begin
      bus_start = 1'b1; // poll the last loaded address
      bus_write = 1'b0;
    end
  end
  // sequencer: command writes, polling, exit, reset
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state       <= S_IDLE;
      op_q        <= OP_NONE;
      idx         <= 3'h0;
      rst_cnt     <= 8'h00;
      have_prev   <= 1'b0;
      prev_toggle <= 1'b0;
      recheck     <= 1'b0;
    end else if (start_req) begin
      op_q      <= req_op;
      idx       <= 3'h0;
      have_prev <= 1'b0;
      recheck   <= 1'b0;
      rst_cnt   <= 8'(RESET_LOW_CYC - 1);
      if (req_op == OP_HW_RESET) begin
        state <= S_RESET; // aborts a running program, its target is then undefined
      end else if (req_op == OP_SET_CFG && wdata_q[1:0] != CFG_AUTO
                   && wdata_q[1:0] != CFG_HOLD) begin
        state <= S_IDLE; // only 00 and 01 are sent
      end else begin
        state <= S_STEP;
      end
    end else begin
      case (state)
        S_STEP: if (kind == K_END) begin
          // sequence issued; for a program the device now times the pulses alone
          state <= (op_q == OP_PROGRAM) ? S_POLL : S_IDLE;
          if (op_q == OP_LOCK_QUERY) begin
            op_q  <= OP_ID_EXIT; // leave identification mode
            idx   <= 3'h0;
            state <= S_STEP;
          end
        end else begin
          state <= S_WAIT;
        end
        S_WAIT: if (bus_done) begin
          idx   <= idx + 3'h1;
          state <= S_STEP;
        end
        S_POLL: state <= S_PWAIT;
        S_PWAIT: if (bus_done) begin
          prev_toggle <= bus_rdata[DQ_TOGGLE];
          have_prev   <= 1'b1;
          state       <= S_POLL;
          if (stopped) begin
            // toggle stopped: exit unless auto return read back the data
            if (cfg_hold || bus_rdata != wdata_q) begin
              op_q  <= OP_ID_EXIT;
              idx   <= 3'h0;
              state <= S_STEP;
            end else begin
              state <= S_IDLE; // device already back in read mode
            end
          end else if (flagged) begin
            // the toggle may stop as the fail bit rises, so read once more
            recheck <= 1'b1;
            if (recheck) begin
              op_q  <= OP_ID_EXIT;
              idx   <= 3'h0;
              state <= S_STEP;
            end
          end
        end
        S_RESET: if (rst_cnt == 8'h00) begin
          state <= S_IDLE;
        end else begin
          rst_cnt <= rst_cnt - 8'h01;
        end
        default: state <= S_IDLE;
      endcase
    end
  end
  // reset pulse of minimum width; device outputs float meanwhile
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      flash_rst_n_o <= 1'b0;
    end else begin
      flash_rst_n_o <= !(start_req && req_op == OP_HW_RESET)
                       && !(state == S_RESET && rst_cnt != 8'h00);
    end
  end
  // config shadow: 00 at power-up, kept over pin reset
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_hold <= 1'b0;
    end else if (state == S_STEP && kind == K_END && op_q == OP_SET_CFG) begin
      cfg_hold <= wdata_q[0];
    end
  end
  // result flags, cleared by each accepted operation except lock_f, which only a reset or a lock query reading a low indicator clears
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      done_f    <= 1'b0;
      fail_f    <= 1'b0;
      low_f     <= 1'b0;
      lock_f    <= 1'b0;
      refused_f <= 1'b0;
      badcfg_f  <= 1'b0;
      rdata_q   <= 16'h0000;
    end else if (start_req) begin
      done_f    <= 1'b0;
      fail_f    <= 1'b0;
      low_f     <= 1'b0;
      refused_f <= 1'b0;
      badcfg_f  <= (req_op == OP_SET_CFG && wdata_q[1:0] != CFG_AUTO
                    && wdata_q[1:0] != CFG_HOLD);
      if (req_op == OP_HW_RESET) begin
        lock_f <= 1'b0; // device drops every lock on reset
      end
    end else begin
      if (wr_acc && reg_index(paddr_i) == 3'h1 && busy) begin
        refused_f <= 1'b1;
      end
      if (state == S_WAIT && bus_done && kind == K_READ) begin
        rdata_q <= bus_rdata;
        if (op_q == OP_LOCK_QUERY) begin
          lock_f <= bus_rdata[DQ_LOCK_IND]; // high means sector refuses writes
        end
      end
      if (state == S_PWAIT && bus_done) begin
        rdata_q <= bus_rdata;
        // status byte valid once the toggle bit stops in held mode
        if (stopped) begin
          fail_f <= cfg_hold ? bus_rdata[DQ_FAIL] : (bus_rdata != wdata_q);
          low_f  <= (cfg_hold || bus_rdata != wdata_q) && bus_rdata[DQ_LOW_SUPPLY];
        end else if (recheck && flagged) begin
          fail_f <= bus_rdata[DQ_FAIL];
          low_f  <= bus_rdata[DQ_LOW_SUPPLY];
        end
      end
      if (state == S_STEP && kind == K_END && op_q != OP_PROGRAM && op_q != OP_LOCK_QUERY) begin
        done_f <= 1'b1;
      end
      if (state == S_PWAIT && bus_done && stopped && !cfg_hold && bus_rdata == wdata_q) begin
        done_f <= 1'b1; // one-to-zero only, so match means programmed
      end
      if (state == S_RESET && rst_cnt == 8'h00) begin
        done_f <= 1'b1;
      end
    end
  end
  fpsl_in_sync u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (flash_dq_i),
    .q_o   (dq_sync)
  );
  fpsl_bus_cycle #(
    .WE_LOW_CYC (WE_CYC),
    .READ_CYC   (READ_CYC)
  ) u_bus (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .start_i   (bus_start),
    .write_i   (bus_write),
    .addr_i    (bus_addr),
    .data_i    (bus_data),
    .abort_i   (start_req && req_op == OP_HW_RESET),
    .dq_sync_i (dq_sync),
    .busy_o    (),
    .done_o    (bus_done),
    .rdata_o   (bus_rdata),
    .addr_o    (flash_addr_o),
    .dq_o      (flash_dq_o),
    .dq_oe_o   (flash_dq_oe_o),
    .ce_n_o    (flash_ce_n_o),
    .oe_n_o    (flash_oe_n_o),
    .we_n_o    (flash_we_n_o)
  );
endmodule // fpsl_host

// [pkg/fpsl_pkg.sv]
// constants, op codes and state types of the flash program/status/lockdown host
// assumes a 10 MHz clk_i and a flash that latches commands on strobe edges
//
// What this block does
// - program is four writes, device pulses itself
// - config 01: exit command needed after success
// - any failure needs exit command
// - set config is four writes, 00/01 only
// - config 01: polling bit high when done
// - host writes exit after fail bit
// - low supply bit set needs exit command
// - all unlocked at reset, six-write lockdown
// - address on late fall, data on rise
package fpsl_pkg;
  localparam int CLK_PERIOD_NS   = 100;
  localparam int T_RESET_LOW_NS  = 500;
  localparam int RESET_LOW_CYC   = (T_RESET_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYNC_LATENCY    = 4;

  // apb register offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_ADDR   = 8'h04;
  localparam logic [7:0] OFS_WDATA  = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_RDATA  = 8'h10;

  // status register bit positions
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_FAIL = 2;
  localparam int ST_LOW  = 3;
  localparam int ST_LOCK = 4;
  localparam int ST_REF  = 5;
  localparam int ST_CFG  = 6;
  localparam int ST_BADC = 7;

  // data pin positions of the status bits
  localparam int DQ_COMPLETION = 7;
  localparam int DQ_TOGGLE     = 6;
  localparam int DQ_FAIL       = 5;
  localparam int DQ_LOW_SUPPLY = 3;
  localparam int DQ_LOCK_IND   = 0;

  localparam logic [19:0] LOCK_IND_OFS = 20'h0_0002;
  localparam logic [1:0]  CFG_AUTO     = 2'b00;
  localparam logic [1:0]  CFG_HOLD     = 2'b01;

  typedef enum logic [2:0] {
    OP_NONE = 3'h0, OP_PROGRAM = 3'h1, OP_SET_CFG = 3'h2, OP_LOCKDOWN = 3'h3,
    OP_ID_EXIT = 3'h4, OP_LOCK_QUERY = 3'h5, OP_READ = 3'h6, OP_HW_RESET = 3'h7
  } fpsl_op_e;

  typedef enum logic [2:0] {
    K_UNLOCK1 = 3'h0, K_UNLOCK2 = 3'h1, K_CMD = 3'h2, K_USER_DATA = 3'h3,
    K_USER_CMD = 3'h4, K_READ = 3'h5, K_END = 3'h6
  } fpsl_step_e;

  // bus write/read sequence of each operation, one step per index
  function automatic fpsl_step_e fpsl_step(input fpsl_op_e op, input logic [2:0] idx);
    fpsl_step_e k;
    k = K_END;
    case (idx)
      3'h0: k = (op == OP_READ) ? K_READ : K_UNLOCK1;
      3'h1: k = (op == OP_READ) ? K_END : K_UNLOCK2;
      3'h2: k = K_CMD;
      3'h3: k = (op == OP_PROGRAM || op == OP_SET_CFG) ? K_USER_DATA :
                (op == OP_LOCKDOWN) ? K_UNLOCK1 : (op == OP_LOCK_QUERY) ? K_READ : K_END;
      3'h4: k = (op == OP_LOCKDOWN) ? K_UNLOCK2 : K_END;
      3'h5: k = (op == OP_LOCKDOWN) ? K_USER_CMD : K_END;
      default: k = K_END;
    endcase
    if (op == OP_NONE || op == OP_HW_RESET) begin
      k = K_END;
    end
    return k;
  endfunction
endpackage

// [logic/fpsl_in_sync.sv]
// three-stage synchroniser for the flash data pins
// assumes pins change freely with respect to clk_i
`timescale 1ns/1ps
module fpsl_in_sync #(
  parameter int W = 16
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  if (W < 1) begin : g_bad_width
    $error("fpsl_in_sync: width must be at least one");
  end

  // first stage feeds only the second; output moves when stages two and three agree
  for (genvar b = 0; b < W; b++) begin : g_bit
    logic s1, s2, s3;
    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
        s1 <= 1'b0;
        s2 <= 1'b0;
        s3 <= 1'b0;
        q_o[b] <= 1'b0;
      end else begin
        s1 <= d_i[b];
        s2 <= s1;
        s3 <= s2;
        if (s2 == s3) begin
          q_o[b] <= s3;
        end
      end
    end
  end
endmodule // fpsl_in_sync

// [logic/fpsl_bus_cycle.sv]
// one asynchronous flash bus cycle: a strobed write or an output-enabled read
// assumes dq_sync_i is the synchronised data bus and the caller waits for done_o
`timescale 1ns/1ps
module fpsl_bus_cycle
  import fpsl_pkg::*;
#(
  parameter int WE_LOW_CYC = 1,
  parameter int READ_CYC   = 5
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        start_i,
  input  wire logic        write_i,
  input  wire logic [19:0] addr_i,
  input  wire logic [15:0] data_i,
  input  wire logic        abort_i,
  input  wire logic [15:0] dq_sync_i,
  output logic             busy_o,
  output logic             done_o,
  output logic      [15:0] rdata_o,
  output logic      [19:0] addr_o,
  output logic      [15:0] dq_o,
  output logic             dq_oe_o,
  output logic             ce_n_o,
  output logic             oe_n_o,
  output logic             we_n_o
);
  if (WE_LOW_CYC < 1 || WE_LOW_CYC > 255 || READ_CYC < 1 || READ_CYC > 255) begin : g_bad
    $error("fpsl_bus_cycle: cycle counts must lie in 1..255");
  end

  typedef enum logic [4:0] {
    B_IDLE = 5'b00001, B_SETUP = 5'b00010, B_STROBE = 5'b00100,
    B_HOLD = 5'b01000, B_READ = 5'b10000
  } fpsl_bus_e;

  fpsl_bus_e  state;
  logic [7:0] cnt;

  assign busy_o = (state != B_IDLE);

  // chip select leads, write strobe falls later so the address is taken on it
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state   <= B_IDLE;
      cnt     <= 8'h00;
      done_o  <= 1'b0;
      rdata_o <= 16'h0000;
      addr_o  <= 20'h0_0000;
      dq_o    <= 16'h0000;
      dq_oe_o <= 1'b0;
      ce_n_o  <= 1'b1;
      oe_n_o  <= 1'b1;
      we_n_o  <= 1'b1;
    end else if (abort_i) begin
      state   <= B_IDLE;
      done_o  <= 1'b0;
      dq_oe_o <= 1'b0;
      ce_n_o  <= 1'b1;
      oe_n_o  <= 1'b1;
      we_n_o  <= 1'b1;
    end else begin
      done_o <= 1'b0;
      case (state)
        B_IDLE: if (start_i) begin
          addr_o  <= addr_i;
          dq_o    <= data_i;
          dq_oe_o <= write_i;
          ce_n_o  <= 1'b0;
          oe_n_o  <= write_i;
          cnt     <= 8'(READ_CYC - 1);
          state   <= write_i ? B_SETUP : B_READ;
        end
        B_SETUP: begin
          we_n_o <= 1'b0;
          cnt    <= 8'(WE_LOW_CYC - 1);
          state  <= B_STROBE;
        end
        B_STROBE: if (cnt == 8'h00) begin
          we_n_o <= 1'b1; // data taken on this rising edge
          state  <= B_HOLD;
        end else begin
          cnt <= cnt - 8'h01;
        end
        B_HOLD: begin
          ce_n_o  <= 1'b1; // data held one cycle past the strobe
          dq_oe_o <= 1'b0;
          done_o  <= 1'b1;
          state   <= B_IDLE;
        end
        B_READ: if (cnt == 8'h00) begin
          rdata_o <= dq_sync_i;
          ce_n_o  <= 1'b1;
          oe_n_o  <= 1'b1;
          done_o  <= 1'b1;
          state   <= B_IDLE;
        end else begin
          cnt <= cnt - 8'h01;
        end
        default: state <= B_IDLE;
      endcase
    end
  end
endmodule // fpsl_bus_cycle

// [test/fpsl_host_monitor.sv]
// checker on the host apb port and flash pins
// assumes binding onto fpsl_host, one clock domain
`timescale 1ns/1ps
module fpsl_host_monitor (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic [7:0]  paddr_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic [19:0] flash_addr_o,
  input wire logic [15:0] flash_dq_o,
  input wire logic        flash_dq_oe_o,
  input wire logic [15:0] flash_dq_i,
  input wire logic        flash_ce_n_o,
  input wire logic        flash_oe_n_o,
  input wire logic        flash_we_n_o,
  input wire logic        flash_rst_n_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // one strobe cycle, then select and data let go
  sequence s_pulse; $fell(flash_we_n_o) ##1 flash_we_n_o; endsequence
  sequence s_free; flash_ce_n_o && !flash_dq_oe_o; endsequence
  a_write_pulse: assert property (s_pulse |=> s_free)
    else $error("strobe not released");
  a_write_held: assert property (!flash_we_n_o |-> !flash_ce_n_o && flash_dq_oe_o &&
    $stable(flash_dq_o) && $stable(flash_addr_o)) else $error("write data moved");
  a_read_quiet: assert property (!flash_oe_n_o |-> flash_we_n_o && !flash_dq_oe_o)
    else $error("bus contention");
  a_idle_gap: assert property ($rose(flash_ce_n_o) |-> flash_ce_n_o[*2])
    else $error("idle gap short");
  a_reset_width: assert property ($fell(flash_rst_n_o) |-> !flash_rst_n_o[*5] ##1 flash_rst_n_o)
    else $error("reset pulse width");
  a_reset_abort: assert property ($past(!flash_rst_n_o) && !flash_rst_n_o |-> flash_we_n_o && flash_oe_n_o)
    else $error("strobe during reset");
  a_apb_ready: assert property (psel_i && penable_i |-> pready_o)
    else $error("no ready");
  a_bad_offset: assert property (psel_i && penable_i && paddr_i > 8'h10 |-> pslverr_o)
    else $error("no slave error");
endmodule // fpsl_host_monitor
bind fpsl_host fpsl_host_monitor fpsl_host_monitor_inst (.*);

// [test/fpsl_flash_model.sv]
// behavioural flash: command decoder, status bits, sector locks
// assumes strobes from fpsl_host; a timer stands in for pulses
`timescale 1ns/1ps
module fpsl_flash_model (
  input  wire logic [19:0] addr_i,
  input  wire logic [15:0] dq_i,
  input  wire logic        ce_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        we_n_i,
  input  wire logic        rst_n_i,
  input  wire logic        low_i,
  output logic      [15:0] dq_o
);
  logic [15:0] mem [logic [19:0]];
  logic [19:0] wa, pa;
  logic [15:0] pd, rd, last;
  logic [31:0] lk;
  logic [1:0]  cfg = 2'b00; // powers up 00, pin reset keeps it
  logic [2:0]  st;
  logic        sm, idm, fl, lo, tg;
  int          busy;
  function automatic logic [15:0] rdm(input logic [19:0] a);
    return mem.exists(a) ? mem[a] : 16'hFFFF;
  endfunction
  initial {lk, pd, last, st, sm, idm, fl, lo, tg, busy} = '0;
  always @(negedge we_n_i) wa = addr_i; // address on late fall
  // decoder; writes ignored while busy
  always @(posedge we_n_i) if (!ce_n_i && rst_n_i && busy == 0) begin
    case (st)
      0: st = (dq_i[7:0] == 8'hAA) ? 3'd1 : 3'd0;
      1: st = (dq_i[7:0] == 8'h55) ? 3'd2 : 3'd0;
      2: begin
        st = (dq_i[7:0] == 8'hA0) ? 3'd3 : (dq_i[7:0] == 8'hD0) ? 3'd4 : (dq_i[7:0] == 8'h80) ? 3'd5 : 3'd0;
        if (dq_i[7:0] == 8'h90) idm = 1'b1;
        if (dq_i[7:0] == 8'hF0) {sm, idm, fl, lo} = '0; // exit
      end
      3: begin // four-cycle program
        st = 0;
        pa = wa;
        pd = dq_i;
        if (lk[wa[19:15]] || low_i) {sm, fl, lo} = {1'b1, !low_i, low_i};
        else begin
          fl = |(dq_i & ~rdm(wa)); // one over zero flagged
          mem[wa] = dq_i & rdm(wa); // only clears bits
          busy = 30;
        end
      end
      4: begin
        st = 0;
        if (dq_i[15:1] == 15'h0) cfg = dq_i[1:0]; // 00 or 01 only
      end
      5: st = (dq_i[7:0] == 8'hAA) ? 3'd6 : 3'd0;
      6: st = (dq_i[7:0] == 8'h55) ? 3'd7 : 3'd0;
      default: begin
        st = 0;
        if (dq_i[7:0] == 8'h60) lk[wa[19:15]] = 1'b1; // six-cycle lockdown
      end
    endcase
  end
  // self-timed end: 00 reads, 01 or failure holds status
  always #100 if (busy != 0) begin
    busy = busy - 1;
    if (busy == 0) sm = cfg[0] | fl;
  end
  always @(negedge oe_n_i) if (busy != 0) tg = ~tg; // flips per read
  // pin reset aborts, corrupts target, unlocks all
  always @(negedge rst_n_i) begin
    if (busy != 0) mem[pa] = ~pd;
    {busy, st, sm, idm, fl, lo, lk} = '0;
  end
  always @* begin
    if (busy != 0) rd = {8'h00, (cfg == 2'b00) ? ~pd[7] : 1'b0, tg, 6'h00};
    else if (sm) rd = {8'h00, 1'b1, tg, fl, 1'b0, lo, 3'h0};
    else if (idm && addr_i[14:0] == 15'h0002) rd = {15'h0000, lk[addr_i[19:15]]};
    else rd = rdm(addr_i); // true data once done
  end
  always @(posedge oe_n_i) last = rd;
  // released bus shows the inverse
  assign dq_o = (!ce_n_i && !oe_n_i && rst_n_i) ? rd : ~last;
endmodule // fpsl_flash_model

// [test/test_fpsl_host.sv]
// self-checking bench: apb master, behavioural flash, read watcher
// assumes fpsl_flash_model and the bound monitor are compiled first
`timescale 1ns/1ps
module test_fpsl_host
  import fpsl_pkg::*;
;
  logic        clk_i, rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, chk, low;
  logic [7:0]  paddr_i;
  logic [31:0] pwdata_i, prdata_o, rv;
  logic [19:0] flash_addr_o;
  logic [15:0] flash_dq_o, flash_dq_i, mdq, d;
  logic        flash_dq_oe_o, flash_ce_n_o, flash_oe_n_o, flash_we_n_o, flash_rst_n_o;
  logic [32:0] exp_q[$], msk_q[$];
  logic [31:0] seed = 32'h0001_7B9C;
  int          num_errors = 0, cmp_count = 0;
  fpsl_host fpsl_host_inst (.*);
  fpsl_flash_model fpsl_flash_model_inst (.addr_i(flash_addr_o), .dq_i(flash_dq_i),
    .ce_n_i(flash_ce_n_o), .oe_n_i(flash_oe_n_o), .we_n_i(flash_we_n_o),
    .rst_n_i(flash_rst_n_o), .low_i(low), .dq_o(mdq));
  assign flash_dq_i = flash_dq_oe_o ? flash_dq_o : mdq; // resolved data pins
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic print_verdict;
    if (num_errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // one apb transfer, then an idle cycle
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd, input logic c);
    int n = 0;
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= wd;
    chk <= c;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 50);
    rv = prdata_o;
    if (n >= 50) num_errors++;
    if (n >= 50) print_verdict;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    chk <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] m, input logic [32:0] e);
    exp_q.push_back(e);
    msk_q.push_back(m);
    apb(1'b0, a, 32'h0, 1'b1);
  endtask
  task automatic st(input logic [7:0] m, input logic [7:0] e);
    rd(OFS_STATUS, {25'h0, m}, {25'h0, e});
  endtask
  task automatic go(input logic [2:0] code, input logic [19:0] a, input logic [15:0] wd);
    apb(1'b1, OFS_ADDR, {12'h0, a}, 1'b0);
    apb(1'b1, OFS_WDATA, {16'h0, wd}, 1'b0);
    apb(1'b1, OFS_CTRL, {29'h0, code}, 1'b0);
  endtask
  task automatic wait_idle;
    int n = 0;
    do begin
      apb(1'b0, OFS_STATUS, 32'h0, 1'b0);
      n++;
    end while (rv[ST_BUSY] !== 1'b0 && n < 2000);
    if (n >= 2000) num_errors++;
    if (n >= 2000) print_verdict;
  endtask
  task automatic op(input logic [2:0] code, input logic [19:0] a = '0, input logic [15:0] wd = '0);
    go(code, a, wd);
    wait_idle;
  endtask
  // watcher: each flagged read against the oldest note
  always @(posedge clk_i) if (chk && psel_i && penable_i && pready_o) begin
    cmp_count++;
    if ((({pslverr_o, prdata_o} ^ exp_q[0]) & msk_q[0]) !== 33'h0) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, {pslverr_o, prdata_o} & msk_q[0], exp_q[0]);
    end
    void'(exp_q.pop_front());
    void'(msk_q.pop_front());
  end
  initial begin
    {psel_i, penable_i, pwrite_i, chk, low, paddr_i, pwdata_i} = '0;
    rst_i = 1'b1;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    st(8'hFF, 8'h00);
    rd(8'h20, 33'h1_0000_0000, 33'h1_0000_0000); // unmapped offset
    seed = xs(seed);
    d = (seed[15:0] | 16'h8000) & 16'hFFFE;
    op(OP_PROGRAM, 20'h0_1234, d);
    st(8'h07, 8'h02);
    op(OP_READ, 20'h0_1234);
    rd(OFS_RDATA, 33'h0_0000_FFFF, {17'h0, d});
    op(OP_PROGRAM, 20'h0_1234, 16'hFFFF);
    st(8'h05, 8'h04);
    op(OP_READ, 20'h0_1234);
    rd(OFS_RDATA, 33'h0_0000_FFFF, {17'h0, d});
    go(OP_PROGRAM, 20'h0_2000, 16'h8421);
    apb(1'b1, OFS_CTRL, 32'h0000_0006, 1'b0); // order while busy
    wait_idle;
    st(8'h27, 8'h22);
    op(OP_LOCKDOWN, 20'h1_8000);
    op(OP_LOCK_QUERY, 20'h1_8000);
    st(8'h10, 8'h10);
    op(OP_ID_EXIT);
    op(OP_LOCK_QUERY, 20'h1_8000);
    st(8'h10, 8'h10);
    op(OP_PROGRAM, 20'h1_8004, 16'h8000);
    st(8'h05, 8'h04);
    op(OP_READ, 20'h1_8004);
    rd(OFS_RDATA, 33'h0_0000_FFFF, 33'h0_0000_FFFF);
    op(OP_HW_RESET);
    op(OP_LOCK_QUERY, 20'h1_8000);
    st(8'h10, 8'h00);
    op(OP_SET_CFG, 20'h0_0000, 16'h0001);
    st(8'hC0, 8'h40);
    op(OP_SET_CFG, 20'h0_0000, 16'h0002);
    st(8'hC0, 8'hC0);
    op(OP_PROGRAM, 20'h1_8004, 16'h8000);
    st(8'h07, 8'h02);
    op(OP_READ, 20'h1_8004);
    rd(OFS_RDATA, 33'h0_0000_FFFF, 33'h0_0000_8000);
    op(OP_HW_RESET);
    st(8'h40, 8'h40);
    low <= 1'b1;
    op(OP_PROGRAM, 20'h0_3000, 16'h8000);
    st(8'h0D, 8'h08);
    print_verdict;
  end
endmodule // test_fpsl_host
